/* File: dv/crg_core_regs_properties.sv */
`timescale 1ns/10ps
module crg_core_regs_properties #(
  parameter int NUM_BANKS = 16
) (
  input wire logic              i_core_clk,
  input wire logic              i_reset,
  input wire logic              i_op_valid,
  input wire logic              i_load_valid,
  input wire logic              i_irq_req,
  input wire logic [1:0]        i_irq_level,
  input wire logic [2:0]        i_gpr_idx,
  input wire logic [15:0]       o_pc,
  input wire logic [15:0]       o_acc,
  input wire logic [15:0]       o_tmp,
  input wire logic [15:0]       o_index_reg,
  input wire logic [15:0]       o_extra_pointer,
  input wire logic [15:0]       o_stack_pointer,
  input wire logic [15:0]       o_program_status_word,
  input wire logic [15:0]       o_gpr_addr,
  input wire logic              o_irq_accept,
  input wire logic              o_pc_in_io,
  input wire logic              o_pc_in_vectors,
  input wire logic              o_busy,
  input wire logic              o_done
);
  localparam logic [7:0] BMASK = 8'(NUM_BANKS - 1);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // ****************************************************************
  // properties
  // ****************************************************************
  wire take = i_op_valid && !o_busy;
  property p_reset_vals;
    disable iff (1'b0)
    i_reset |=> o_pc == 16'hfffd && o_program_status_word == 16'h0030 && o_acc == 16'h0000;
  endproperty
  property p_irq;
    !$past(i_reset) |-> o_irq_accept == $past(i_irq_req && o_program_status_word[6]
                                              && (i_irq_level < o_program_status_word[5:4]));
  endproperty
  property p_gpr;
    !$past(i_reset) |-> o_gpr_addr == 16'h0100 + $past(i_gpr_idx)
                        + (16'($past(o_program_status_word[15:8] & BMASK)) << 3);
  endproperty
  property p_io;
    !$past(i_reset) |-> o_pc_in_io == ($past(o_pc) < 16'h0080);
  endproperty
  property p_vec;
    !$past(i_reset) |-> o_pc_in_vectors == ($past(o_pc) >= 16'hffc0);
  endproperty
  property p_busy;
    take |=> o_busy;
  endproperty
  property p_done;
    take |-> ##[2:3] o_done;
  endproperty
  property p_pulse;
    o_done |=> !o_done;
  endproperty
  property p_hold;
    (!$past(i_reset) && !$past(o_busy) && !$past(i_load_valid) && !$past(i_op_valid))
      |-> $stable({o_acc, o_tmp, o_index_reg, o_extra_pointer, o_stack_pointer});
  endproperty
  // ****************************************************************
  // assertions and covers
  // ****************************************************************
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  a_irq: assert property (p_irq) else $error("irq accept wrong");
  a_gpr: assert property (p_gpr) else $error("bank address wrong");
  a_io: assert property (p_io) else $error("io area flag wrong");
  a_vec: assert property (p_vec) else $error("vector area flag wrong");
  a_busy: assert property (p_busy) else $error("op not taken");
  a_done: assert property (p_done) else $error("op did not finish");
  a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
  a_hold: assert property (p_hold) else $error("register changed while idle");
  c_done: cover property (o_done);
  c_irq: cover property (o_irq_accept);
  c_vec: cover property (o_pc_in_vectors);
endmodule
bind crg_core_regs crg_core_regs_properties #(.NUM_BANKS(NUM_BANKS)) i_crg_core_regs_properties (
  .i_core_clk, .i_reset, .i_op_valid, .i_load_valid, .i_irq_req, .i_irq_level, .i_gpr_idx,
  .o_pc, .o_acc, .o_tmp, .o_index_reg, .o_extra_pointer, .o_stack_pointer,
  .o_program_status_word, .o_gpr_addr, .o_irq_accept, .o_pc_in_io, .o_pc_in_vectors,
  .o_busy, .o_done);

/* File: dv/tb.sv */
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); err_total++; end end
module tb;
  import crg_pkg::*;
  logic             i_core_clk;
  logic             i_reset = 1'b1;
  logic             i_op_valid = 1'b0;
  crg_op_t          i_op = CRG_OP_ADD;
  logic             i_op_wide = 1'b0;
  crg_sel_t         i_dst_sel = CRG_SEL_IX;
  logic             i_flags_upd = 1'b1;
  logic             i_load_valid = 1'b0;
  crg_sel_t         i_load_sel = CRG_SEL_A;
  logic [15:0]      i_load_data = 16'h0000;
  logic             i_pc_inc = 1'b0;
  logic             i_irq_req = 1'b0;
  logic [1:0]       i_irq_level = 2'h0;
  logic [2:0]       i_gpr_idx = 3'h0;
  logic [15:0]      o_pc, o_acc, o_tmp, o_index_reg, o_extra_pointer, o_stack_pointer;
  logic [15:0]      o_program_status_word, o_gpr_addr;
  logic             o_irq_accept, o_pc_in_io, o_pc_in_vectors, o_busy, o_done;
  int               err_total = 0;
  int               checks_done = 0;
  crg_core_regs #(.NUM_BANKS(16)) i_crg_core_regs (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_op_valid(i_op_valid), .i_op(i_op),
    .i_op_wide(i_op_wide), .i_dst_sel(i_dst_sel), .i_flags_upd(i_flags_upd),
    .i_load_valid(i_load_valid), .i_load_sel(i_load_sel), .i_load_data(i_load_data),
    .i_pc_inc(i_pc_inc), .i_irq_req(i_irq_req), .i_irq_level(i_irq_level),
    .i_gpr_idx(i_gpr_idx), .o_pc(o_pc), .o_acc(o_acc), .o_tmp(o_tmp),
    .o_index_reg(o_index_reg), .o_extra_pointer(o_extra_pointer),
    .o_stack_pointer(o_stack_pointer), .o_program_status_word(o_program_status_word),
    .o_gpr_addr(o_gpr_addr), .o_irq_accept(o_irq_accept), .o_pc_in_io(o_pc_in_io),
    .o_pc_in_vectors(o_pc_in_vectors), .o_busy(o_busy), .o_done(o_done));
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic finish_test();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic load(crg_sel_t sel, logic [15:0] d);
    i_load_valid = 1'b1;
    i_load_sel = sel;
    i_load_data = d;
    @(negedge i_core_clk);
    i_load_valid = 1'b0;
    @(negedge i_core_clk);
  endtask
  task automatic run_op(crg_op_t op, logic wide, logic [15:0] a, logic [15:0] b,
                        logic [15:0] res, logic [15:0] mask, logic [15:0] flags);
    int n;
    load(CRG_SEL_A, a);
    load(CRG_SEL_T, b);
    i_op_valid = 1'b1;
    i_op = op;
    i_op_wide = wide;
    @(negedge i_core_clk);
    i_op_valid = 1'b0;
    `CHK(o_busy, 1'b1)
    n = 0;
    while (o_done !== 1'b1 && n < 10) begin
      @(negedge i_core_clk);
      n++;
    end
    if (n == 10) begin
      err_total++;
      finish_test();
    end
    @(negedge i_core_clk);
    `CHK(o_index_reg, res)
    `CHK(o_program_status_word & mask, flags)
  endtask
  task automatic irq(logic [1:0] lvl, logic exp);
    i_irq_req = 1'b1;
    i_irq_level = lvl;
    @(negedge i_core_clk);
    `CHK(o_irq_accept, exp)
    i_irq_req = 1'b0;
    @(negedge i_core_clk);
    `CHK(o_irq_accept, 1'b0)
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(negedge i_core_clk);
    `CHK(o_pc, CRG_PC_RST)
    `CHK(o_program_status_word, 16'h0030)
    `CHK(o_gpr_addr, 16'h0100)
    i_reset = 1'b0;
    for (int i = 1; i < 6; i++) load(crg_sel_t'(i), 16'(i * 16'h1111));
    `CHK(o_acc, 16'h1111)
    `CHK(o_tmp, 16'h2222)
    `CHK(o_index_reg, 16'h3333)
    `CHK(o_extra_pointer, 16'h4444)
    `CHK(o_stack_pointer, 16'h5555)
    run_op(CRG_OP_ADD, 1'b0, 16'h000f, 16'h0001, 16'h0010, 16'h008f, 16'h0080);
    run_op(CRG_OP_ADD, 1'b0, 16'h00ff, 16'h0001, 16'h0000, 16'h008f, 16'h0085);
    run_op(CRG_OP_ADD, 1'b0, 16'h007f, 16'h0001, 16'h0080, 16'h008f, 16'h008a);
    run_op(CRG_OP_SUB, 1'b0, 16'h0000, 16'h0001, 16'h00ff, 16'h008f, 16'h0089);
    run_op(CRG_OP_SUB, 1'b0, 16'h0080, 16'h0001, 16'h007f, 16'h008f, 16'h0082);
    run_op(CRG_OP_SHL, 1'b0, 16'h0081, 16'h0000, 16'h0002, 16'h0001, 16'h0001);
    run_op(CRG_OP_SHR, 1'b0, 16'h0002, 16'h0000, 16'h0001, 16'h0001, 16'h0000);
    run_op(CRG_OP_ADD, 1'b0, 16'h12ff, 16'h3401, 16'h0000, 16'h008f, 16'h0085);
    run_op(CRG_OP_ADD, 1'b1, 16'h00ff, 16'h0001, 16'h0100, 16'h008f, 16'h0080);
    run_op(CRG_OP_PASS, 1'b0, 16'h0055, 16'h0000, 16'h0055, 16'h0083, 16'h0000);
    i_dst_sel = CRG_SEL_SP;
    i_flags_upd = 1'b0;
    run_op(CRG_OP_ADD, 1'b0, 16'h00ff, 16'h0001, 16'h0055, 16'h008f, 16'h0000);
    `CHK(o_stack_pointer, 16'h0000)
    load(CRG_SEL_PS, 16'h0560);
    `CHK(o_program_status_word, 16'h0560)
    irq(2'h1, 1'b1);
    irq(2'h2, 1'b0);
    irq(2'h3, 1'b0);
    i_gpr_idx = 3'h3;
    @(negedge i_core_clk);
    `CHK(o_gpr_addr, 16'h012b)
    load(CRG_SEL_PS, 16'h1f20);
    i_gpr_idx = 3'h7;
    @(negedge i_core_clk);
    `CHK(o_gpr_addr, 16'h017f)
    irq(2'h0, 1'b0);
    load(CRG_SEL_PC, 16'h007f);
    @(negedge i_core_clk);
    `CHK(o_pc_in_io, 1'b1)
    i_pc_inc = 1'b1;
    @(negedge i_core_clk);
    i_pc_inc = 1'b0;
    @(negedge i_core_clk);
    `CHK(o_pc, 16'h0080)
    `CHK(o_pc_in_io, 1'b0)
    load(CRG_SEL_PC, 16'hffbf);
    i_pc_inc = 1'b1;
    @(negedge i_core_clk);
    i_pc_inc = 1'b0;
    @(negedge i_core_clk);
    `CHK(o_pc_in_vectors, 1'b1)
    load(CRG_SEL_PS, 16'h0740);
    `CHK(o_program_status_word, 16'h0740)
    i_reset = 1'b1;
    repeat (2) @(negedge i_core_clk);
    `CHK(o_program_status_word, 16'h0030)
    `CHK(o_pc, CRG_PC_RST)
    `CHK(o_gpr_addr, 16'h0100)
    i_reset = 1'b0;
    @(negedge i_core_clk);
    `CHK(o_index_reg, 16'h0000)
    finish_test();
  end
endmodule

/* File: verilog/crg_alu.sv */
`timescale 1ns/10ps
module crg_alu (
  crg_alu_if.alu a
);
  import crg_pkg::*;

  // ****************************************************************
  // byte and word arithmetic
  // ****************************************************************
  wire [8:0]  add8  = {1'b0, a.opa[7:0]} + {1'b0, a.opb[7:0]};
  wire [8:0]  sub8  = {1'b0, a.opa[7:0]} - {1'b0, a.opb[7:0]};
  wire [4:0]  addn  = {1'b0, a.opa[3:0]} + {1'b0, a.opb[3:0]};
  wire [4:0]  subn  = {1'b0, a.opa[3:0]} - {1'b0, a.opb[3:0]};
  wire [16:0] add16 = {1'b0, a.opa} + {1'b0, a.opb};
  wire [16:0] sub16 = {1'b0, a.opa} - {1'b0, a.opb};
  wire        is_sub = (a.op == CRG_OP_SUB);
  wire        is_add = (a.op == CRG_OP_ADD);
  wire        sa = a.wide ? a.opa[15] : a.opa[7];
  wire        sb = a.wide ? a.opb[15] : a.opb[7];
  wire [15:0] sum = a.wide ? add16[15:0] : {8'h00, add8[7:0]};
  wire [15:0] dif = a.wide ? sub16[15:0] : {8'h00, sub8[7:0]};
  wire [15:0] shl = a.wide ? {a.opa[14:0], 1'b0} : {8'h00, a.opa[6:0], 1'b0};
  wire [15:0] shr = a.wide ? {1'b0, a.opa[15:1]} : {9'h000, a.opa[7:1]};
  wire [15:0] pas = a.wide ? a.opa : {8'h00, a.opa[7:0]};

  assign a.res = is_add ? sum : is_sub ? dif :
                 (a.op == CRG_OP_SHL) ? shl : (a.op == CRG_OP_SHR) ? shr : pas;
  wire        rs = a.wide ? a.res[15] : a.res[7];

  // half carry between bit 3 and 4
  assign a.half  = is_add ? addn[4] : is_sub ? subn[4] : 1'b0;
  assign a.neg   = rs;
  assign a.zero  = (a.res == 16'h0000);
  assign a.ovf   = is_add ? (sa == sb) && (rs != sa) :
                   is_sub ? (sa != sb) && (rs != sa) : 1'b0;
  assign a.carry = is_add ? (a.wide ? add16[16] : add8[8]) :
                   is_sub ? (a.wide ? sub16[16] : sub8[8]) :
                   (a.op == CRG_OP_SHL) ? sa :
                   (a.op == CRG_OP_SHR) ? a.opa[0] : 1'b0;
endmodule

/* File: verilog/crg_alu_if.sv */
`timescale 1ns/10ps
interface crg_alu_if;
  import crg_pkg::*;
  logic [15:0] opa;
  logic [15:0] opb;
  crg_op_t     op;
  logic        wide;
  logic [15:0] res;
  logic        half;
  logic        neg;
  logic        zero;
  logic        ovf;
  logic        carry;
  modport core (output opa, opb, op, wide, input res, half, neg, zero, ovf, carry);
  modport alu  (input opa, opb, op, wide, output res, half, neg, zero, ovf, carry);
endinterface

/* File: verilog/crg_core_regs.sv */
`timescale 1ns/10ps
// Overview of operation
// - sixteen-bit program counter points at the instruction being fetched.
// - sixteen-bit accumulator; byte operations use only its low byte.
// - sixteen-bit temporary accumulator is second operand; low byte for bytes.
// - sixteen-bit index register and separate sixteen-bit extra pointer.
// - sixteen-bit stack pointer addresses the stack area.
// - status word high byte is bank pointer, low byte condition codes.
// - half carry set on carry or borrow between bits 3 and 4.
// - interrupt enable permits interrupts when 1; reset clears it.
// - two-bit level field; accept request only of higher priority.
// - negative flag follows result most significant bit.
// - zero flag set when result equals zero.
// - overflow flag set on two's complement overflow.
// - carry flag set on carry or borrow out of bit 7, or out of bit 15 for wide operations.
// - shifts put the shifted-out bit into carry.
// - general registers are bytes in memory, eight per bank, 16 banks.
// - register addressing uses bank selected by the bank pointer.
// - one 64 Kbyte space; I/O area at the lowest address.
// - data area sits directly above the I/O area.
// - program fills from top; vectors at the highest addresses.
module crg_core_regs #(
  parameter int NUM_BANKS = 16
) (
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_reset,
  // operation request
  input  wire logic              i_op_valid,
  input  wire crg_pkg::crg_op_t  i_op,
  input  wire logic              i_op_wide,
  input  wire crg_pkg::crg_sel_t i_dst_sel,
  input  wire logic              i_flags_upd,
  // direct register load
  input  wire logic              i_load_valid,
  input  wire crg_pkg::crg_sel_t i_load_sel,
  input  wire logic [15:0]       i_load_data,
  input  wire logic              i_pc_inc,
  // interrupt request
  input  wire logic              i_irq_req,
  input  wire logic [1:0]        i_irq_level,
  // general register addressing
  input  wire logic [2:0]        i_gpr_idx,
  // outputs
  output logic [15:0]            o_pc,
  output logic [15:0]            o_acc,
  output logic [15:0]            o_tmp,
  output logic [15:0]            o_index_reg,
  output logic [15:0]            o_extra_pointer,
  output logic [15:0]            o_stack_pointer,
  output logic [15:0]            o_program_status_word,
  output logic [15:0]            o_gpr_addr,
  output logic                   o_irq_accept,
  output logic                   o_pc_in_io,
  output logic                   o_pc_in_vectors,
  output logic                   o_busy,
  output logic                   o_done
);
  import crg_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] pc_q, acc_q, tmp_q, ix_q, ep_q, sp_q;
  logic [7:0]  bsp_q, ccb_q;
  logic [15:0] res_q;
  logic [15:0] gpr_addr_q;
  logic        irq_acc_q, in_io_q, in_vec_q;
  crg_state_t  st_q, st_d;
  crg_op_t     op_q;
  logic        wide_q, upd_q, busy_q;
  crg_sel_t    dst_q;
  logic [7:0]  flags_q;

  crg_alu_if alu_bus ();

  crg_alu u_alu (
    .a (alu_bus)
  );

  // ****************************************************************
  // operand selection
  // ****************************************************************
  assign alu_bus.opa  = acc_q;
  assign alu_bus.opb  = tmp_q;
  assign alu_bus.op   = op_q;
  assign alu_bus.wide = wide_q;

  wire [7:0] ccb_alu = {alu_bus.half, ccb_q[CRG_CCB_IE], ccb_q[CRG_CCB_IL_HI],
                        ccb_q[CRG_CCB_IL_LO], alu_bus.neg, alu_bus.zero,
                        alu_bus.ovf, alu_bus.carry};

  // ****************************************************************
  // state machine
  // ****************************************************************
  always_comb begin
    case (st_q)
      CRG_ST_IDLE:  st_d = i_op_valid ? CRG_ST_EXEC : CRG_ST_IDLE;
      CRG_ST_EXEC:  st_d = CRG_ST_WRITE;
      CRG_ST_WRITE: st_d = CRG_ST_DONE;
      CRG_ST_DONE:  st_d = CRG_ST_IDLE;
      default:      st_d = CRG_ST_IDLE;
    endcase
  end

  wire exec_now  = (st_q == CRG_ST_EXEC);
  wire write_now = (st_q == CRG_ST_WRITE);
  wire load_now  = i_load_valid && (st_q == CRG_ST_IDLE) && !i_op_valid;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st_q   <= CRG_ST_IDLE;
      busy_q <= 1'b0;
      op_q   <= CRG_OP_PASS;
      wide_q <= 1'b0;
      upd_q  <= 1'b0;
      dst_q  <= CRG_SEL_A;
    end else begin
      st_q   <= st_d;
      busy_q <= (st_d != CRG_ST_IDLE);
      if (st_q == CRG_ST_IDLE && i_op_valid) begin
        op_q   <= i_op;
        wide_q <= i_op_wide;
        upd_q  <= i_flags_upd;
        dst_q  <= i_dst_sel;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      res_q   <= 16'h0000;
      flags_q <= CRG_CCB_RST;
    end else if (exec_now) begin
      res_q   <= alu_bus.res;
      flags_q <= ccb_alu;
    end
  end

  // ****************************************************************
  // register write decode
  // ****************************************************************
  wire [15:0] wr_data = write_now ? res_q : i_load_data;
  wire        wr_en   = write_now || load_now;
  wire [2:0]  wr_sel  = write_now ? dst_q : i_load_sel;
  wire        wr_pc   = wr_en && wr_sel == CRG_SEL_PC;
  wire        wr_a    = wr_en && wr_sel == CRG_SEL_A;
  wire        wr_t    = wr_en && wr_sel == CRG_SEL_T;
  wire        wr_ix   = wr_en && wr_sel == CRG_SEL_IX;
  wire        wr_ep   = wr_en && wr_sel == CRG_SEL_EP;
  wire        wr_sp   = wr_en && wr_sel == CRG_SEL_SP;
  wire        wr_ps   = wr_en && wr_sel == CRG_SEL_PS;
  wire        wr_flag = write_now && upd_q;
  wire [15:0] pc_next = pc_q + 16'h0001;

  // ****************************************************************
  // dedicated registers
  // ****************************************************************
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pc_q <= CRG_PC_RST;
    end else if (wr_pc) begin
      pc_q <= wr_data;
    end else if (i_pc_inc) begin
      pc_q <= pc_next;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      acc_q <= 16'h0000;
      tmp_q <= 16'h0000;
    end else begin
      if (wr_a) acc_q <= wr_data;
      if (wr_t) tmp_q <= wr_data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ix_q <= 16'h0000;
      ep_q <= 16'h0000;
      sp_q <= CRG_SP_RST;
    end else begin
      if (wr_ix) ix_q <= wr_data;
      if (wr_ep) ep_q <= wr_data;
      if (wr_sp) sp_q <= wr_data;
    end
  end

  // ****************************************************************
  // program status word
  // ****************************************************************
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      bsp_q <= CRG_BSP_RST;
      ccb_q <= CRG_CCB_RST;
    end else if (wr_ps) begin
      bsp_q <= wr_data[15:8];
      ccb_q <= wr_data[7:0];
    end else if (wr_flag) begin
      ccb_q <= flags_q;
    end
  end

  // ****************************************************************
  // interrupt acceptance
  // ****************************************************************
  wire [1:0] il_field  = ccb_q[CRG_CCB_IL_HI:CRG_CCB_IL_LO];
  wire       irq_ok    = ccb_q[CRG_CCB_IE] && (i_irq_level < il_field);

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      irq_acc_q <= 1'b0;
    end else begin
      irq_acc_q <= i_irq_req && irq_ok;
    end
  end

  // ****************************************************************
  // general register bank address and memory map
  // ****************************************************************
  localparam int BSP_W = $clog2(NUM_BANKS);
  wire [BSP_W-1:0] bank_sel = bsp_q[BSP_W-1:0];
  wire [15:0] bank_off = 16'(bank_sel) << CRG_BANK_SHIFT;
  wire [15:0] gpr_addr = CRG_BANK_BASE + bank_off + {13'h0000, i_gpr_idx};
  wire        pc_io    = (pc_q < CRG_DATA_BASE);
  wire        pc_vec   = (pc_q >= CRG_VECTOR_BASE);

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      gpr_addr_q <= CRG_BANK_BASE;
      in_io_q    <= 1'b0;
      in_vec_q   <= 1'b0;
    end else begin
      gpr_addr_q <= gpr_addr;
      in_io_q    <= pc_io;
      in_vec_q   <= pc_vec;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_pc                  = pc_q;
  assign o_acc                 = acc_q;
  assign o_tmp                 = tmp_q;
  assign o_index_reg           = ix_q;
  assign o_extra_pointer       = ep_q;
  assign o_stack_pointer       = sp_q;
  assign o_program_status_word = {bsp_q, ccb_q};
  assign o_gpr_addr            = gpr_addr_q;
  assign o_irq_accept          = irq_acc_q;
  assign o_pc_in_io            = in_io_q;
  assign o_pc_in_vectors       = in_vec_q;
  assign o_busy                = busy_q;
  assign o_done                = st_q[3];
endmodule

/* File: verilog/crg_pkg.sv */
package crg_pkg;

  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam int          CRG_WORD_W      = 16;
  localparam int          CRG_BYTE_W      = 8;
  localparam logic [15:0] CRG_PC_RST      = 16'hfffd;
  localparam logic [15:0] CRG_SP_RST      = 16'h0000;
  localparam logic [7:0]  CRG_CCB_RST     = 8'h30;
  localparam logic [7:0]  CRG_BSP_RST     = 8'h00;

  // ****************************************************************
  // condition code byte field positions
  // ****************************************************************
  localparam int CRG_CCB_HALF  = 7;
  localparam int CRG_CCB_IE    = 6;
  localparam int CRG_CCB_IL_HI = 5;
  localparam int CRG_CCB_IL_LO = 4;
  localparam int CRG_CCB_NEG   = 3;
  localparam int CRG_CCB_ZERO  = 2;
  localparam int CRG_CCB_OVF   = 1;
  localparam int CRG_CCB_CARRY = 0;

  // ****************************************************************
  // address map
  // ****************************************************************
  localparam logic [15:0] CRG_IO_BASE     = 16'h0000;
  localparam logic [15:0] CRG_DATA_BASE   = 16'h0080;
  localparam logic [15:0] CRG_BANK_BASE   = 16'h0100;
  localparam int          CRG_BANK_SHIFT  = 3;
  localparam logic [15:0] CRG_VECTOR_BASE = 16'hffc0;
  localparam int          CRG_BANKS_MAX   = 16;
  localparam int          CRG_REGS_PER_BK = 8;

  // ****************************************************************
  // register select codes and alu operations
  // ****************************************************************
  typedef enum logic [2:0] {
    CRG_SEL_PC = 3'h0,
    CRG_SEL_A  = 3'h1,
    CRG_SEL_T  = 3'h2,
    CRG_SEL_IX = 3'h3,
    CRG_SEL_EP = 3'h4,
    CRG_SEL_SP = 3'h5,
    CRG_SEL_PS = 3'h6
  } crg_sel_t;

  typedef enum logic [2:0] {
    CRG_OP_ADD = 3'h0,
    CRG_OP_SUB = 3'h1,
    CRG_OP_SHL = 3'h2,
    CRG_OP_SHR = 3'h3,
    CRG_OP_PASS = 3'h4
  } crg_op_t;

  typedef enum logic [3:0] {
    CRG_ST_IDLE  = 4'b0001,
    CRG_ST_EXEC  = 4'b0010,
    CRG_ST_WRITE = 4'b0100,
    CRG_ST_DONE  = 4'b1000
  } crg_state_t;

endpackage
